// ---- host_port_debug_control_tb.sv ----
// Self-checking testbench of the host port and debug control block.
`timescale 1ns/1ps
`default_nettype none
module host_port_debug_control_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    hpd_pkg::hpd_host_s hostPins;
    hpd_pkg::hpd_core_s coreBus = '0;
    logic [5:0]  basePage = 6'h29;
    logic [7:0]  hostDataOut, coreRdata, codeData, q;
    logic        hostDataOe, irqAny, coreReset, coreRun, hit;
    logic [15:0] hostIrq;
    logic [15:0] corePc = 16'h1234;
    logic [12:0] codeAddr = 13'h0000;
    logic        breakHit = 1'b0;
    logic        instrDone = 1'b0;
    int          n_errors = 0;
    int          n_compared = 0;
    logic [29:0] rows [4] = '{{14'h0010, 8'ha5, 8'ha5},
        {14'h2000, 8'h3c, 8'h3c}, {14'h2ff7, 8'h81, 8'h81},
        {14'h3000, 8'h77, 8'h00}};
    logic [6:0]  pages [4] = '{7'h40, 7'h01, 7'h7b, 7'h3c};
    initial forever #2.5 clk_sys = ~clk_sys;
    hpd_host_port i_dut (.clk_sys(clk_sys), .reset(reset),
        .hostPins(hostPins), .basePage(basePage),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .hostIrq(hostIrq), .irqAny(irqAny), .coreBus(coreBus),
        .coreRdata(coreRdata), .codeAddr(codeAddr), .codeData(codeData),
        .breakHit(breakHit), .instrDone(instrDone), .corePc(corePc),
        .coreReset(coreReset), .coreRun(coreRun));
    hpd_host_model i_host (.clk_sys(clk_sys), .pins(hostPins),
        .rdData(hostDataOut), .rdOe(hostDataOe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hw(input logic [13:0] o, input logic [7:0] d);
        i_host.cyc({basePage, o}, d, 1'b1, 1'b1, q, hit);
    endtask : hw
    task automatic hr(input logic [13:0] o, input logic [7:0] e);
        i_host.cyc({basePage, o}, 8'h00, 1'b0, 1'b1, q, hit);
        chk({hit, q}, {1'b1, e});
    endtask : hr
    task automatic cacc(input logic [11:0] a, input logic [7:0] d,
                        input logic wr);
        @(posedge clk_sys) coreBus <= '{a, d, wr, !wr};
        @(posedge clk_sys) coreBus <= '{a, d, 1'b0, 1'b0};
        #1;
    endtask : cacc
    task automatic pulse(input logic brk);
        @(posedge clk_sys) {breakHit, instrDone} <= {brk, !brk};
        @(posedge clk_sys) {breakHit, instrDone} <= 2'b00;
        #1;
    endtask : pulse
    task automatic final_report;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        hw(14'h2ff8, 8'h01);
        chk({coreReset, coreRun}, 2'b10);
        foreach (rows[i]) begin
            hw(rows[i][29:16], rows[i][15:8]);
            hr(rows[i][29:16], rows[i][7:0]);
        end
        @(posedge clk_sys) codeAddr <= 13'h0010;
        @(posedge clk_sys) #1 chk(codeData, 8'ha5);
        cacc(12'h000, 8'h00, 1'b0);
        chk(coreRdata, 8'h3c);
        cacc(12'h001, 8'hc3, 1'b1);
        hr(14'h2001, 8'hc3);
        hw(14'h2ff8, 8'h00);
        chk({coreReset, coreRun}, 2'b01);
        hw(14'h0010, 8'h00);
        hr(14'h0010, 8'ha5);
        hw(14'h2ffb, 8'h07);
        cacc(12'hffa, 8'h04, 1'b1);
        chk(irqAny, 1'b1);
        for (int n = 3; n < 16; n++) begin
            hw(14'h2ff9, {4'h8, 4'(n)});
            chk(hostIrq, 16'h0001 << n);
        end
        hw(14'h2ff9, 8'h05);
        chk(hostIrq, 16'h0000);
        hw(14'h2ffb, 8'h00);
        chk(irqAny, 1'b0);
        hw(14'h2ffb, 8'h07);
        hw(14'h2ffa, 8'h04);
        chk(irqAny, 1'b0);
        pulse(1'b1);
        chk(coreRun, 1'b0);
        hr(14'h2ffc, 8'h34);
        hr(14'h2ffd, 8'h12);
        hr(14'h2ffa, 8'h01);
        hr(14'h2ff8, 8'h02);
        chk({irqAny, coreRun}, 2'b10);
        hw(14'h2ff8, 8'h04);
        chk(coreRun, 1'b1);
        pulse(1'b0);
        chk(coreRun, 1'b0);
        hr(14'h2ffa, 8'h03);
        hw(14'h2ff8, 8'h00);
        chk(coreRun, 1'b1);
        i_host.cyc({basePage, 14'h2000}, 8'h00, 1'b0, 1'b0, q, hit);
        chk(hit, 1'b0);
        i_host.cyc({6'h2a, 14'h2000}, 8'h00, 1'b0, 1'b1, q, hit);
        chk(hit, 1'b0);
        foreach (pages[i]) begin
            basePage <= pages[i][5:0];
            i_host.cyc({pages[i][5:0], 14'h2000}, 8'h00, 1'b0, 1'b1, q, hit);
            chk(hit, pages[i][6]);
        end
        basePage <= 6'h29;
        i_host.setRst(1'b0);
        repeat (8) @(posedge clk_sys);
        chk({coreReset, coreRun}, 2'b10);
        i_host.setRst(1'b1);
        repeat (8) @(posedge clk_sys);
        chk({coreReset, coreRun}, 2'b01);
        final_report();
    end
endmodule : host_port_debug_control_tb
bind hpd_host_port hpd_host_port_monitor i_mon (.clk_sys(clk_sys),
    .reset(reset), .hostPins(hostPins), .basePage(basePage),
    .hostDataOe(hostDataOe), .hostIrq(hostIrq), .irqAny(irqAny),
    .breakHit(breakHit), .coreReset(coreReset), .coreRun(coreRun));
`default_nettype wire

// ---- hpd_cfg.svh ----
// Constants for the host port and debug control block.
`ifndef HPD_CFG_SVH
`define HPD_CFG_SVH
`define HPD_ADDR_W      20
`define HPD_PAGE_W      6
`define HPD_PAGE_MSB    19
`define HPD_PAGE_LSB    14
`define HPD_OFS_MSB     13
`define HPD_SEG_ZERO    6'h00
`define HPD_SEG_LO      6'h29
`define HPD_SEG_HI      6'h3b
`define HPD_CODE_AW     13
`define HPD_DP_AW       12
`define HPD_WIN_CODE    1'b0
`define HPD_WIN_DP      2'b10
`define HPD_REG_CTRL    12'hff8
`define HPD_REG_IRQSEL  12'hff9
`define HPD_REG_STATUS  12'hffa
`define HPD_REG_MASK    12'hffb
`define HPD_REG_PCLO    12'hffc
`define HPD_REG_PCHI    12'hffd
`define HPD_CTRL_SWRST  0
`define HPD_CTRL_WAIT   1
`define HPD_CTRL_STEP   2
`define HPD_IRQ_EN      7
`define HPD_IRQ_MIN     4'h3
`define HPD_IRQ_MAX     4'hf
`define HPD_ST_BRK      0
`define HPD_ST_STEP     1
`define HPD_ST_SOFT     2
`define HPD_ST_MASK     8'h07
`define HPD_RST_BYTE    8'h00
`define HPD_BUS_RST     32'h0000000f
`endif

// ---- hpd_host_model.sv ----
// Host processor model that runs byte cycles on the host pins.
`timescale 1ns/1ps
`default_nettype none
module hpd_host_model (
    input  wire logic         clk_sys, // system clock
    output var hpd_pkg::hpd_host_s pins, // host bus pins
    input  wire logic [7:0]   rdData,  // device read data
    input  wire logic         rdOe     // low while device drives
);
    initial pins = '{20'h00000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};
    // Data not driven by the host shows the inverse of the last value.
    task automatic cyc(input logic [19:0] a, input logic [7:0] d,
                       input logic wr, input logic cs,
                       output logic [7:0] q, output logic hit);
        hit = 1'b0;
        q = 8'h00;
        @(posedge clk_sys);
        pins <= '{a, wr ? d : ~pins.data, wr, !wr, !cs, pins.resetN};
        repeat (10) @(posedge clk_sys) if (rdOe === 1'b0) begin
            hit = 1'b1;
            q = rdData;
        end
        pins <= '{a, ~pins.data, 1'b1, 1'b1, 1'b1, pins.resetN};
        repeat (6) @(posedge clk_sys);
    endtask : cyc
    task automatic setRst(input logic v);
        @(posedge clk_sys);
        pins.resetN <= v;
    endtask : setRst
endmodule : hpd_host_model
`default_nettype wire

// ---- hpd_host_port.sv ----
// Host bus port, shared memory and debug control of the embedded core.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "hpd_cfg.svh"
// Notes on behaviour
// (R1) Upper host address bits must equal the base page pins to respond.
// (R2) The device occupies a 16K byte window of host memory space.
// (R3) Base segment is zero or one of A400 through EC00.
// (R4) Host picks one IRQ line 3..15; interrupts appear only there.
// (R5) A chip select input must also be asserted for a response.
// (R6) Code RAM is host-writable only in core reset; release runs it.
// (R7) Core resets by hardware pin or by host software reset bit.
// (R8) A 4K shared RAM is read and written by host and core.
// (R9) Control registers sit inside the shared RAM address range.
// (R10) At a breakpoint, store PC, interrupt host, then stall.
// (R11) Core stays halted until the host clears the wait bit.
// (R12) With step bit set, host is interrupted after every instruction.
// (R13) Core software can raise a host interrupt on its own.
// (R14) While stalled, core state is frozen; shared RAM keeps answering.
module hpd_host_port #(
    parameter int CODE_DEPTH = 8192,
    parameter int DP_DEPTH   = 4096
) (
    input  wire logic                     clk_sys,    // 200 MHz clock
    input  wire logic                     reset,      // sync reset, high
    input  wire hpd_pkg::hpd_host_s       hostPins,   // raw host bus pins
    input  wire logic [`HPD_PAGE_W-1:0]   basePage,   // base page pins
    output logic      [7:0]               hostDataOut,// host read data
    output logic                          hostDataOe, // low while driving
    output logic      [15:0]              hostIrq,    // host IRQ lines
    output logic                          irqAny,     // unmasked event
    input  wire hpd_pkg::hpd_core_s       coreBus,    // core data port
    output logic      [7:0]               coreRdata,  // core read data
    input  wire logic [`HPD_CODE_AW-1:0]  codeAddr,   // core fetch addr
    output logic      [7:0]               codeData,   // core fetch data
    input  wire logic                     breakHit,   // breakpoint pulse
    input  wire logic                     instrDone,  // instr done pulse
    input  wire logic [15:0]              corePc,     // core PC
    output logic                          coreReset,  // core held reset
    output logic                          coreRun     // core may advance
);
    hpd_pkg::hpd_host_s hs;
    hpd_pkg::hpd_state_e state_reg;
    hpd_pkg::hpd_state_e state_next;

    logic [7:0] codeMem [CODE_DEPTH];
    logic [7:0] dpMem   [DP_DEPTH];

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] irqSel_reg;
    logic [7:0] irqSel_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] pcLo_reg;
    logic [7:0] pcLo_next;
    logic [7:0] pcHi_reg;
    logic [7:0] pcHi_next;
    logic       rdPrev_reg;
    logic       wrPrev_reg;
    logic [7:0] hostRd_reg;
    logic [7:0] hostRd_next;
    logic       oe_reg;
    logic       oe_next;
    logic [7:0] coreRd_reg;
    logic [7:0] coreRd_next;
    logic [7:0] codeRd_reg;

    logic       segValid;
    logic       hostSel;
    logic       hostRdStart;
    logic       hostWrStart;
    logic       hostCode;
    logic       hostDp;
    logic [11:0] hostDpAddr;
    logic       hostDpReg;
    logic       coreDpReg;
    logic [7:0] hostSet;
    logic [7:0] hostClr;
    logic [7:0] hwSet;
    logic       stallEntry;
    logic       stepHit;
    logic       irqLineOk;

    hpd_sync #(
        .W       ($bits(hpd_pkg::hpd_host_s)),
        .RST_VAL (`HPD_BUS_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (hostPins),
        .dout    (hs)
    );

    function automatic logic isReg(input logic [11:0] a);
        isReg = (a >= `HPD_REG_CTRL) && (a <= `HPD_REG_PCHI);
    endfunction : isReg

    function automatic logic [7:0] regRead(input logic [11:0] a,
                                           input logic [7:0] d);
        case (a)
            `HPD_REG_CTRL:   regRead = ctrl_reg;
            `HPD_REG_IRQSEL: regRead = irqSel_reg;
            `HPD_REG_STATUS: regRead = status_reg;
            `HPD_REG_MASK:   regRead = mask_reg;
            `HPD_REG_PCLO:   regRead = pcLo_reg;
            `HPD_REG_PCHI:   regRead = pcHi_reg;
            default:         regRead = d;
        endcase
    endfunction : regRead

    // Host decode: segment check, page match and chip select together.
    // A strobe counts only on its synchronised falling edge, so a long
    // host cycle is taken once and never repeated while the pin stays low.
    // An unsupported base page blocks every host read and write cycle, which keeps
    // a misstrapped device off the bus instead of answering by accident.
    always_comb begin
        segValid = (basePage == `HPD_SEG_ZERO) ||
                   ((basePage >= `HPD_SEG_LO) &&
                    (basePage <= `HPD_SEG_HI)); // R3
        hostSel = segValid && !hs.csN && // R5
                  (hs.addr[`HPD_PAGE_MSB:`HPD_PAGE_LSB] == basePage); // R1
        hostRdStart = hostSel && !hs.rdN && rdPrev_reg;
        hostWrStart = hostSel && !hs.wrN && wrPrev_reg;
        hostCode = (hs.addr[`HPD_OFS_MSB] == `HPD_WIN_CODE); // R2
        hostDp = (hs.addr[`HPD_OFS_MSB -: 2] == `HPD_WIN_DP); // R2
        hostDpAddr = hs.addr[`HPD_DP_AW-1:0];
        hostDpReg = hostDp && isReg(hostDpAddr); // R9
        coreDpReg = isReg(coreBus.addr); // R9
    end

    // Core reset from the host pin, the software bit or system reset.
    assign coreReset = reset || !hs.resetN ||
                       ctrl_reg[`HPD_CTRL_SWRST]; // R7

    // Debug sequencing.
    // Any reset source forces the hold state, so a stall cannot outlive
    // a reset and the core always restarts from a clean run state.
    // A break and a step in the same cycle are recorded as a break.
    always_comb begin
        stepHit = instrDone && ctrl_reg[`HPD_CTRL_STEP]; // R12
        stallEntry = 1'b0;
        state_next = state_reg;
        case (state_reg)
            hpd_pkg::HPD_HOLD: begin
                state_next = hpd_pkg::HPD_RUN; // R6
            end
            hpd_pkg::HPD_RUN: begin
                if (breakHit || stepHit) begin
                    stallEntry = 1'b1;
                    state_next = hpd_pkg::HPD_STALL; // R10
                end
            end
            hpd_pkg::HPD_STALL: begin
                if (!ctrl_reg[`HPD_CTRL_WAIT]) begin
                    state_next = hpd_pkg::HPD_RUN; // R11
                end
            end
            default: begin
                state_next = hpd_pkg::HPD_HOLD;
            end
        endcase
        if (coreReset) begin
            stallEntry = 1'b0;
            state_next = hpd_pkg::HPD_HOLD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= hpd_pkg::HPD_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Stalled or held, the core gets no advance; memory is still served.
    assign coreRun = (state_reg == hpd_pkg::HPD_RUN) && !coreReset; // R14

    // Control registers; hardware set wins over a host clear.
    always_comb begin
        hostSet = `HPD_RST_BYTE;
        hostClr = `HPD_RST_BYTE;
        hwSet = `HPD_RST_BYTE;
        ctrl_next = ctrl_reg;
        irqSel_next = irqSel_reg;
        mask_next = mask_reg;
        pcLo_next = pcLo_reg;
        pcHi_next = pcHi_reg;
        if (hostWrStart && hostDpReg) begin
            case (hostDpAddr)
                `HPD_REG_CTRL:   ctrl_next = hs.data; // R11
                `HPD_REG_IRQSEL: irqSel_next = hs.data; // R4
                `HPD_REG_STATUS: hostClr = hs.data & `HPD_ST_MASK;
                `HPD_REG_MASK:   mask_next = hs.data & `HPD_ST_MASK;
                default:         hostClr = `HPD_RST_BYTE;
            endcase
        end
        if (coreBus.wr && (coreBus.addr == `HPD_REG_STATUS)) begin
            hwSet[`HPD_ST_SOFT] = coreBus.wdata[`HPD_ST_SOFT]; // R13
        end
        if (stallEntry) begin
            ctrl_next[`HPD_CTRL_WAIT] = 1'b1; // R11
            pcLo_next = corePc[7:0]; // R10
            pcHi_next = corePc[15:8]; // R10
            hwSet[`HPD_ST_BRK] = breakHit; // R10
            hwSet[`HPD_ST_STEP] = !breakHit; // R12
        end
        hostSet = hwSet;
        status_next = (status_reg & ~hostClr) | hostSet;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg   <= `HPD_RST_BYTE;
            irqSel_reg <= `HPD_RST_BYTE;
            status_reg <= `HPD_RST_BYTE;
            mask_reg   <= `HPD_RST_BYTE;
            pcLo_reg   <= `HPD_RST_BYTE;
            pcHi_reg   <= `HPD_RST_BYTE;
        end else begin
            ctrl_reg   <= ctrl_next;
            irqSel_reg <= irqSel_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            pcLo_reg   <= pcLo_next;
            pcHi_reg   <= pcHi_next;
        end
    end

    // Interrupt routing to the single selected host line.
    // Lines below three or a disabled selection leave every line low.
    always_comb begin
        irqAny = |(status_reg & mask_reg);
        irqLineOk = irqSel_reg[`HPD_IRQ_EN] &&
                    (irqSel_reg[3:0] >= `HPD_IRQ_MIN) &&
                    (irqSel_reg[3:0] <= `HPD_IRQ_MAX); // R4
        hostIrq = 16'h0000;
        if (irqLineOk) begin
            hostIrq[irqSel_reg[3:0]] = irqAny; // R4
        end
    end

    // Host read path and bus drive.
    // The read byte is captured once per strobe and held until the next.
    always_comb begin
        hostRd_next = hostRd_reg;
        if (hostRdStart) begin
            if (hostCode) begin
                hostRd_next = codeMem[hs.addr[`HPD_CODE_AW-1:0]];
            end else if (hostDp) begin
                hostRd_next = regRead(hostDpAddr,
                                      dpMem[hostDpAddr]); // R8
            end else begin
                hostRd_next = `HPD_RST_BYTE;
            end
        end
        oe_next = !(hostSel && !hs.rdN && !rdPrev_reg);
        coreRd_next = coreRd_reg;
        if (coreBus.rd) begin
            coreRd_next = regRead(coreBus.addr,
                                  dpMem[coreBus.addr]); // R8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdPrev_reg <= 1'b1;
            wrPrev_reg <= 1'b1;
            hostRd_reg <= `HPD_RST_BYTE;
            oe_reg     <= 1'b1;
            coreRd_reg <= `HPD_RST_BYTE;
        end else begin
            rdPrev_reg <= hs.rdN;
            wrPrev_reg <= hs.wrN;
            hostRd_reg <= hostRd_next;
            oe_reg     <= oe_next;
            coreRd_reg <= coreRd_next;
        end
    end

    // Memory arrays; a core write lands after a host write to one byte.
    always_ff @(posedge clk_sys) begin
        if (hostWrStart && hostCode && coreReset) begin
            codeMem[hs.addr[`HPD_CODE_AW-1:0]] <= hs.data; // R6
        end
        if (hostWrStart && hostDp && !hostDpReg) begin
            dpMem[hostDpAddr] <= hs.data; // R8
        end
        if (coreBus.wr && !coreDpReg) begin
            dpMem[coreBus.addr] <= coreBus.wdata; // R8
        end
        codeRd_reg <= codeMem[codeAddr];
    end

    assign hostDataOut = hostRd_reg;
    assign hostDataOe  = oe_reg;
    assign coreRdata   = coreRd_reg;
    assign codeData    = codeRd_reg;
endmodule : hpd_host_port
`default_nettype wire

// ---- hpd_host_port_monitor.sv ----
// Concurrent checks on the host port and debug control block.
`timescale 1ns/1ps
`default_nettype none
module hpd_host_port_monitor (
    input wire logic               clk_sys,    // system clock
    input wire logic               reset,      // sync reset
    input wire hpd_pkg::hpd_host_s hostPins,   // host pins
    input wire logic [5:0]         basePage,   // base page pins
    input wire logic               hostDataOe, // low while driving
    input wire logic [15:0]        hostIrq,    // host IRQ lines
    input wire logic               irqAny,     // unmasked event
    input wire logic               breakHit,   // breakpoint pulse
    input wire logic               coreReset,  // core held reset
    input wire logic               coreRun     // core may advance
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_IRQ_ONEHOT: assert property ($onehot0(hostIrq))
        else $error("more than one host IRQ line high");
    AST_IRQ_RANGE: assert property (hostIrq[2:0] == 3'h0)
        else $error("IRQ line below 3 driven");
    AST_IRQ_CAUSE: assert property (|hostIrq |-> irqAny)
        else $error("IRQ line high without an event");
    AST_CS: assert property (hostPins.csN [*7] |=> hostDataOe)
        else $error("data driven while not selected");
    AST_PAGE: assert property
        ((hostPins.addr[19:14] != basePage) [*7] |=> hostDataOe)
        else $error("data driven on page mismatch");
    AST_RST: assert property (disable iff (1'b0)
        reset |-> coreReset && !coreRun)
        else $error("core not held during reset");
    AST_HWRST: assert property (!hostPins.resetN [*7] |-> coreReset)
        else $error("hardware reset pin ignored");
    AST_HOLD: assert property (coreReset |-> !coreRun)
        else $error("core runs while held in reset");
    AST_BREAK: assert property (coreRun && breakHit |=> !coreRun)
        else $error("core did not stall at breakpoint");
endmodule : hpd_host_port_monitor
`default_nettype wire

// ---- hpd_pkg.sv ----
// Types shared by the host port and debug control block.
`default_nettype none
package hpd_pkg;
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  data;
        logic        rdN;
        logic        wrN;
        logic        csN;
        logic        resetN;
    } hpd_host_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } hpd_core_s;

    typedef enum logic [1:0] {
        HPD_HOLD  = 2'b00,
        HPD_RUN   = 2'b01,
        HPD_STALL = 2'b11
    } hpd_state_e;
endpackage : hpd_pkg
`default_nettype wire

// ---- hpd_sync.sv ----
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module hpd_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         reset,   // synchronous reset
    input  wire logic [W-1:0] din,     // asynchronous input
    output logic      [W-1:0] dout     // filtered value
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // The output follows only once the second and third stages agree.
    always_comb begin
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_reg  <= RST_VAL;
            s2_reg  <= RST_VAL;
            s3_reg  <= RST_VAL;
            out_reg <= RST_VAL;
        end else begin
            s1_reg  <= din;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : hpd_sync
`default_nettype wire
